// >>> logic/ldr_pkg.sv
// shared constants for the led driver status, id and configuration slice
package ldr_pkg;

  // ****************************************************************
  // register offsets (command byte values)
  // ****************************************************************
  localparam logic [7:0] STATUS_OFS = 8'h02; // fault and state flags
  localparam logic [7:0] IDENT_OFS  = 8'h03; // identification word
  localparam logic [7:0] DC_OFS     = 8'h07; // dc current level
  localparam logic [7:0] CFG_OFS    = 8'h08; // driver configuration

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] STATUS_RST = 8'h00; // no fault latched
  localparam logic [7:0] DC_RST     = 8'hff; // full dc current
  localparam logic [7:0] CFG_RST    = 8'h1f; // 600 khz, 5.8 v threshold

  // ****************************************************************
  // status field positions
  // ****************************************************************
  localparam int ST_TWO_CH_BIT = 5; // two channels shut down
  localparam int ST_ONE_CH_BIT = 4; // one channel shut down
  localparam int ST_BL_BIT     = 3; // backlight on
  localparam int ST_OVC_BIT    = 2; // input overcurrent
  localparam int ST_THERM_BIT  = 1; // thermal trip
  localparam int ST_FAULT_BIT  = 0; // sticky summary

  // ****************************************************************
  // identification word layout
  // ****************************************************************
  localparam int         ID_MARK_BIT  = 7;    // led driver marker
  localparam logic       ID_MARK_VAL  = 1'b1; // marker always one
  localparam int         ID_MAKER_LSB = 3;    // maker code low bit
  localparam int         ID_MAKER_W   = 4;    // maker code width
  localparam int         ID_REV_W     = 3;    // revision width
  localparam logic [3:0] MAKER_NONE   = 4'hf; // code not implemented
  localparam logic [2:0] REV_FIRST    = 3'h0; // first released silicon

  // ****************************************************************
  // configuration word layout
  // ****************************************************************
  localparam int CFG_DIRECT_BIT = 7; // direct dimming passthrough
  localparam int CFG_FSW_BIT    = 2; // 1 = 600 khz, 0 = 1.2 mhz
  localparam int CFG_VSC_HI     = 1; // short threshold select msb
  localparam int CFG_VSC_LO     = 0; // short threshold select lsb

  // ****************************************************************
  // serial link
  // ****************************************************************
  localparam logic [3:0] BIT_IDLE = 4'hf; // before first data bit
  localparam logic [3:0] BIT_ACK  = 4'h8; // ninth (ack) slot
  localparam logic [3:0] BIT_LAST = 4'h7; // last data bit
  localparam int         SYNC_STAGES = 2; // dimming input synchroniser

  // transaction phases of the byte protocol
  typedef enum logic [2:0] {
    LDR_IDLE, LDR_ADDR, LDR_CMD, LDR_WDATA, LDR_RDATA, LDR_SKIP
  } ldr_xfer_e;

endpackage

// >>> logic/ldr_sync.sv
// two-flop synchroniser for an asynchronous level
`timescale 1ns/10ps
module ldr_sync #(
  parameter int STAGES = 2 // number of flops in the chain
) (
  input  wire logic mclk,    // system clock
  input  wire logic sys_rst, // synchronous reset, active high
  input  wire logic async_in, // level from outside
  output logic      sync_out  // level in mclk domain
);

  // ****************************************************************
  // chain
  // ****************************************************************
  logic [STAGES-1:0] chain_q; // first stage read only by the second
  logic [STAGES-1:0] chain_d; // next chain value

  // shift one stage per clock
  always_comb begin
    chain_d = {chain_q[STAGES-2:0], async_in};
  end

  // register the chain
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      chain_q <= '0;
    end else begin
      chain_q <= chain_d;
    end
  end

  assign sync_out = chain_q[STAGES-1]; // last stage only

endmodule

// >>> logic/ldr_i2c_bits.sv
// bit-level engine for the two-wire serial register link
`timescale 1ns/10ps
module ldr_i2c_bits (
  input  wire logic       mclk,       // system clock
  input  wire logic       sys_rst,    // synchronous reset
  input  wire logic       scl_in,     // serial clock level
  input  wire logic       sda_in,     // serial data level
  input  wire logic       ack_en,     // pull data low in ack slot
  input  wire logic       tx_en,      // device sends data bits
  input  wire logic [7:0] tx_byte,    // byte to send, msb first
  output logic            sda_out,    // open drain: always low
  output logic            sda_oe,     // high while pulling low
  output logic            start_seen, // start or repeated start
  output logic            stop_seen,  // stop condition
  output logic            byte_done,  // pulse: rx_byte valid
  output logic            ack_done,   // pulse: ack slot sampled
  output logic            master_ack, // host acked our byte
  output logic      [7:0] rx_byte     // last received byte
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic       scl_q, sda_q;           // previous line samples
  logic [3:0] cnt_q, cnt_d;           // bit slot, idle before first
  logic [7:0] shift_q, shift_d;       // incoming bits
  logic       drive_q, drive_d;       // data line pulled low
  logic       bdone_q, bdone_d;       // byte received pulse
  logic       adone_q, adone_d;       // ack sampled pulse
  logic       mack_q, mack_d;         // host ack value
  logic [7:0] rx_q, rx_d;             // completed byte
  logic [3:0] nxt;                    // slot after falling edge
  logic [2:0] idx;                    // tx bit for next slot
  logic       scl_rise, scl_fall;     // clock edges

  assign scl_rise   = scl_in & ~scl_q;
  assign scl_fall   = ~scl_in & scl_q;
  // data moving while the clock stays high frames a transfer
  assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_seen  = scl_in & scl_q & ~sda_q & sda_in;
  assign nxt = (cnt_q == ldr_pkg::BIT_ACK || cnt_q == ldr_pkg::BIT_IDLE)
               ? 4'h0 : cnt_q + 4'h1;
  assign idx = 3'(ldr_pkg::BIT_LAST - nxt);

  // next bit, shift and drive decisions
  always_comb begin
    cnt_d   = cnt_q;
    shift_d = shift_q;
    drive_d = drive_q;
    bdone_d = 1'b0;
    adone_d = 1'b0;
    mack_d  = mack_q;
    rx_d    = rx_q;
    if (start_seen || stop_seen) begin
      cnt_d   = ldr_pkg::BIT_IDLE;  // wait for first falling edge
      drive_d = 1'b0;               // release line at framing
    end else if (scl_rise && cnt_q < ldr_pkg::BIT_ACK) begin
      shift_d = {shift_q[6:0], sda_in};
      if (cnt_q == ldr_pkg::BIT_LAST) begin
        rx_d    = {shift_q[6:0], sda_in};
        bdone_d = 1'b1;
      end
    end else if (scl_rise && cnt_q == ldr_pkg::BIT_ACK) begin
      mack_d  = ~sda_in;            // low means acknowledge
      adone_d = 1'b1;
    end else if (scl_fall) begin
      cnt_d = nxt;
      // change the data line only while the clock is low
      if (nxt == ldr_pkg::BIT_ACK) begin
        drive_d = ack_en;
      end else begin
        drive_d = tx_en & ~tx_byte[idx];
      end
    end
  end

  // register engine state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      cnt_q   <= ldr_pkg::BIT_IDLE;
      shift_q <= 8'h00;
      drive_q <= 1'b0;
      bdone_q <= 1'b0;
      adone_q <= 1'b0;
      mack_q  <= 1'b0;
      rx_q    <= 8'h00;
    end else begin
      scl_q   <= scl_in;
      sda_q   <= sda_in;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      drive_q <= drive_d;
      bdone_q <= bdone_d;
      adone_q <= adone_d;
      mack_q  <= mack_d;
      rx_q    <= rx_d;
    end
  end

  assign sda_out    = 1'b0;
  assign sda_oe     = drive_q;
  assign byte_done  = bdone_q;
  assign ack_done   = adone_q;
  assign master_ack = mack_q;
  assign rx_byte    = rx_q;

endmodule

// >>> logic/ldr_regs.sv
// status, identification, dc level and configuration register slice
`timescale 1ns/10ps

// Functional notes
// - id word: marker, maker code, revision
// - id bits read-only, marker always one
// - maker code encoding, 15 means none
// - revision starts at zero, then increments
// - status bit 5: two channels shut down
// - status bit 4: one channel shut down
// - status bit 3: backlight on indicator
// - status bit 2: input overcurrent
// - status bit 1: thermal trip
// - status bit 0: or of all faults
// - summary sticky; clear by toggle or write zero
// - status reserved bits read zero, ignore writes
// - dc level 8-bit read/write, live change
// - dc write leaves pwm setting untouched
// - dc read returns level in effect
// - dc level resets to maximum
// - brightness is dc times pwm, 16 bits
// - configuration resets to documented default
// - rate select: 1 slow, 0 fast
// - short threshold select, zero disables
// - direct option passes synced external dimming
module ldr_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2c, // serial device address
  // arbitrary neutral maker code, not a real vendor assignment
  parameter logic [3:0] MAKER_CODE = 4'h5,
  parameter logic [2:0] REVISION   = ldr_pkg::REV_FIRST
) (
  input  wire logic        mclk,                         // 10 mhz clock
  input  wire logic        sys_rst,                      // sync reset
  input  wire logic        scl_in,                       // serial clock
  input  wire logic        sda_in,                       // serial data in
  output logic             sda_out,                      // data out level
  output logic             sda_oe,                       // data pull low
  input  wire logic        two_channel_shutdown_flag,    // fault input
  input  wire logic        single_channel_shutdown_flag, // fault input
  input  wire logic        backlight_on_indicator,       // state input
  input  wire logic        input_overcurrent_flag,       // fault input
  input  wire logic        thermal_trip_flag,            // fault input
  input  wire logic        backlight_enable_control,     // control bit
  input  wire logic [7:0]  pwm_duty_level,               // pwm setting
  input  wire logic        internal_dimming_pwm,         // internal pwm
  input  wire logic        external_dimming_input,       // pwm pin
  output logic      [7:0]  dc_current_level_field,       // dc level
  output logic             switching_rate_select,        // boost rate
  output logic      [1:0]  short_threshold_select,       // short level
  output logic             direct_dimming_passthrough,   // direct mode
  output logic             dimming_drive,                // sink gate
  output logic      [15:0] combined_brightness           // dc x pwm
);

  // ****************************************************************
  // serial engine
  // ****************************************************************
  logic       start_seen;  // start or repeated start
  logic       stop_seen;   // stop condition
  logic       byte_done;   // received byte pulse
  logic       ack_done;    // ack slot sampled pulse
  logic       master_ack;  // host acked a read byte
  logic [7:0] rx_byte;     // received byte
  logic       ack_q;       // acknowledge the current byte
  logic       ack_d;       // next acknowledge
  logic [7:0] tx_q;        // byte being read out
  logic [7:0] tx_d;        // next read byte
  ldr_pkg::ldr_xfer_e st_q; // transaction phase
  ldr_pkg::ldr_xfer_e st_d; // next phase

  ldr_i2c_bits u_bits (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .ack_en     (ack_q),
    .tx_en      (st_q == ldr_pkg::LDR_RDATA),
    .tx_byte    (tx_q),
    .sda_out    (sda_out),
    .sda_oe     (sda_oe),
    .start_seen (start_seen),
    .stop_seen  (stop_seen),
    .byte_done  (byte_done),
    .ack_done   (ack_done),
    .master_ack (master_ack),
    .rx_byte    (rx_byte)
  );

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [7:0] cmd_q, cmd_d;     // register pointer (command byte)
  logic [7:0] dc_q, dc_d;       // dc current level
  logic [7:0] cfg_q, cfg_d;     // configuration word
  logic       fault_q, fault_d; // sticky summary fault
  logic       blc_q, blc_d;     // last backlight enable value
  logic [15:0] prod_q, prod_d;  // registered brightness product
  logic       any_fault;        // any live fault condition
  logic       fault_clr;        // summary clear request
  logic       wr_strobe;        // register write this cycle
  logic [7:0] ident_word;       // fixed identification word
  logic [7:0] status_word;      // assembled status word
  logic [7:0] rd_data;          // read mux for cmd_d target
  logic       ext_sync;         // synchronised external dimming

  // ****************************************************************
  // read side
  // ****************************************************************
  // id word is constant wiring, so writes can never touch it
  always_comb begin
    ident_word = 8'h00;
    ident_word[ldr_pkg::ID_MARK_BIT] = ldr_pkg::ID_MARK_VAL;
    ident_word[ldr_pkg::ID_MAKER_LSB +: ldr_pkg::ID_MAKER_W] =
      MAKER_CODE;
    ident_word[ldr_pkg::ID_REV_W-1:0] = REVISION;
  end

  // live flags except bit 0; upper bits left at zero
  always_comb begin
    status_word = ldr_pkg::STATUS_RST;
    status_word[ldr_pkg::ST_TWO_CH_BIT] =
      two_channel_shutdown_flag;
    status_word[ldr_pkg::ST_ONE_CH_BIT] =
      single_channel_shutdown_flag;
    status_word[ldr_pkg::ST_BL_BIT] = backlight_on_indicator;
    status_word[ldr_pkg::ST_OVC_BIT] = input_overcurrent_flag;
    status_word[ldr_pkg::ST_THERM_BIT] = thermal_trip_flag;
    status_word[ldr_pkg::ST_FAULT_BIT] = fault_q;
  end

  // select read data for the register named by the next pointer
  always_comb begin
    unique case (cmd_d)
      ldr_pkg::STATUS_OFS: rd_data = status_word;
      ldr_pkg::IDENT_OFS:  rd_data = ident_word;
      ldr_pkg::DC_OFS:     rd_data = dc_q;
      ldr_pkg::CFG_OFS:    rd_data = cfg_q;
      default:             rd_data = 8'h00; // outside this slice
    endcase
  end

  // ****************************************************************
  // transaction sequencer
  // ****************************************************************
  // address, command, then data bytes; reads return the pointed word
  always_comb begin
    st_d  = st_q;
    ack_d = ack_q;
    tx_d  = tx_q;
    cmd_d = cmd_q;
    wr_strobe = 1'b0;
    if (ack_done) begin
      ack_d = 1'b0; // release after the ack slot
    end
    if (stop_seen) begin
      st_d  = ldr_pkg::LDR_IDLE;
      ack_d = 1'b0;
    end else if (start_seen) begin
      st_d  = ldr_pkg::LDR_ADDR; // repeated start also lands here
      ack_d = 1'b0;
    end else begin
      unique case (st_q)
        ldr_pkg::LDR_IDLE, ldr_pkg::LDR_SKIP: begin
          // wait for the next start
        end
        ldr_pkg::LDR_ADDR: begin
          if (byte_done) begin
            if (rx_byte[7:1] != DEV_ADDR) begin
              st_d = ldr_pkg::LDR_SKIP; // not ours, stay silent
            end else if (rx_byte[0]) begin
              st_d  = ldr_pkg::LDR_RDATA;
              ack_d = 1'b1;
              tx_d  = rd_data;          // snapshot at address time
            end else begin
              st_d  = ldr_pkg::LDR_CMD;
              ack_d = 1'b1;
            end
          end
        end
        ldr_pkg::LDR_CMD: begin
          if (byte_done) begin
            cmd_d = rx_byte;            // pointer for data or read
            ack_d = 1'b1;
            st_d  = ldr_pkg::LDR_WDATA;
          end
        end
        ldr_pkg::LDR_WDATA: begin
          if (byte_done) begin
            wr_strobe = 1'b1;           // extra bytes rewrite same word
            ack_d     = 1'b1;
          end
        end
        ldr_pkg::LDR_RDATA: begin
          if (ack_done) begin
            if (master_ack) begin
              tx_d = rd_data;           // host wants another copy
            end else begin
              st_d = ldr_pkg::LDR_SKIP; // host ended the read
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // register writes and sticky fault
  // ****************************************************************
  // toggle of the enable, or a zero written to bit 0, clears summary
  assign any_fault = two_channel_shutdown_flag
                   | single_channel_shutdown_flag
                   | input_overcurrent_flag
                   | thermal_trip_flag;
  assign fault_clr = (backlight_enable_control != blc_q)
                   | (wr_strobe && cmd_q == ldr_pkg::STATUS_OFS
                      && !rx_byte[ldr_pkg::ST_FAULT_BIT]);

  // storage updates; only dc and configuration take data
  always_comb begin
    dc_d  = dc_q;
    cfg_d = cfg_q;
    blc_d = backlight_enable_control;
    // a live fault sets in the same cycle as any clear
    fault_d = (fault_q & ~fault_clr) | any_fault;
    if (wr_strobe) begin
      unique case (cmd_q)
        ldr_pkg::DC_OFS:  dc_d  = rx_byte;
        ldr_pkg::CFG_OFS: cfg_d = rx_byte;
        default: begin
          // id and status data bits are read-only here
        end
      endcase
    end
    // product of both dimming levels, 8 x 8 gives 16 bits
    prod_d = 16'(dc_q) * 16'(pwm_duty_level);
  end

  // register everything; reset loads documented defaults
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q    <= ldr_pkg::LDR_IDLE;
      ack_q   <= 1'b0;
      tx_q    <= 8'h00;
      cmd_q   <= 8'h00;
      dc_q    <= ldr_pkg::DC_RST;
      cfg_q   <= ldr_pkg::CFG_RST;
      fault_q <= ldr_pkg::STATUS_RST[ldr_pkg::ST_FAULT_BIT];
      blc_q   <= 1'b0;
      prod_q  <= 16'h0000;
    end else begin
      st_q    <= st_d;
      ack_q   <= ack_d;
      tx_q    <= tx_d;
      cmd_q   <= cmd_d;
      dc_q    <= dc_d;
      cfg_q   <= cfg_d;
      fault_q <= fault_d;
      blc_q   <= blc_d;
      prod_q  <= prod_d;
    end
  end

  // ****************************************************************
  // dimming path
  // ****************************************************************
  // external pin is asynchronous; costs two clocks of delay
  ldr_sync #(
    .STAGES (ldr_pkg::SYNC_STAGES)
  ) u_ext_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in (external_dimming_input),
    .sync_out (ext_sync)
  );

  // direct option bypasses the internal pwm entirely
  assign dimming_drive = cfg_q[ldr_pkg::CFG_DIRECT_BIT]
                         ? ext_sync : internal_dimming_pwm;

  // ****************************************************************
  // analog control outputs
  // ****************************************************************
  // bits 6..3 are kept only for read back; bits 5..3 rely on host
  assign dc_current_level_field = dc_q;
  assign switching_rate_select  = cfg_q[ldr_pkg::CFG_FSW_BIT];
  assign short_threshold_select =
    cfg_q[ldr_pkg::CFG_VSC_HI:ldr_pkg::CFG_VSC_LO];
  assign direct_dimming_passthrough = cfg_q[ldr_pkg::CFG_DIRECT_BIT];
  assign combined_brightness    = prod_q;

endmodule

// >>> bench/ldr_regs_sva.sv
// port checker for the register slice
`timescale 1ns/10ps
module ldr_regs_sva (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        scl_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic [7:0]  pwm_duty_level,
  input wire logic        internal_dimming_pwm,
  input wire logic        external_dimming_input,
  input wire logic [7:0]  dc_current_level_field,
  input wire logic        switching_rate_select,
  input wire logic [1:0]  short_threshold_select,
  input wire logic        direct_dimming_passthrough,
  input wire logic        dimming_drive,
  input wire logic [15:0] combined_brightness
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // run of serial clock high; writes land early in a high phase
  logic [3:0] hi_q, hi_d;
  logic [3:0] cfg;
  assign cfg = {direct_dimming_passthrough, switching_rate_select,
                short_threshold_select};
  always_comb begin
    hi_d = scl_in ? hi_q + 4'(hi_q != 4'hf) : 4'h0;
  end
  always_ff @(posedge mclk) begin
    hi_q <= sys_rst ? 4'h0 : hi_d;
  end
  dc_reset_a: assert property (
    $past(sys_rst) |-> dc_current_level_field == 8'hff) else $error("dc");
  cfg_reset_a: assert property (
    $past(sys_rst) |-> cfg == 4'h7) else $error("cfg reset");
  product_a: assert property (
    !$past(sys_rst) |-> combined_brightness ==
    16'($past(dc_current_level_field)) * 16'($past(pwm_duty_level)))
    else $error("product");
  direct_path_a: assert property (
    direct_dimming_passthrough && !$past(sys_rst, 2) |->
    dimming_drive == $past(external_dimming_input, 2)) else $error("direct");
  pwm_path_a: assert property (
    !direct_dimming_passthrough |-> dimming_drive == internal_dimming_pwm)
    else $error("pwm path");
  dc_quiet_a: assert property (
    hi_q > 4'h8 |-> $stable(dc_current_level_field)) else $error("dc idle");
  cfg_quiet_a: assert property (
    hi_q > 4'h8 |-> $stable(cfg)) else $error("cfg idle");
  sda_low_a: assert property (!sda_out) else $error("sda level");
  // device may only start pulling data low while the serial clock is low
  drive_edge_a: assert property (
    $rose(sda_oe) |-> !scl_in) else $error("sda drive edge");
  cover property (direct_dimming_passthrough);
  cover property (short_threshold_select == 2'h0);
  cover property ($changed(dc_current_level_field));
endmodule
bind ldr_regs ldr_regs_sva u_sva (
  .mclk(mclk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe),
  .pwm_duty_level(pwm_duty_level),
  .internal_dimming_pwm(internal_dimming_pwm),
  .external_dimming_input(external_dimming_input),
  .dc_current_level_field(dc_current_level_field),
  .switching_rate_select(switching_rate_select),
  .short_threshold_select(short_threshold_select),
  .direct_dimming_passthrough(direct_dimming_passthrough),
  .dimming_drive(dimming_drive), .combined_brightness(combined_brightness));

// >>> bench/ldr_host.sv
// two-wire host model for the register link
`timescale 1ns/10ps
module ldr_host #(
  parameter logic [6:0] ADDR = 7'h2c // device address
) (
  input  wire logic mclk,   // system clock
  input  wire logic sda_in, // resolved data wire
  output logic      scl,    // serial clock
  output logic      sda_oe  // high pulls data low
);
  initial {scl, sda_oe} = 2'h2;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // data moves a cycle after the clock fall, never mimics start/stop
  task automatic slot(input logic b, output logic r);
    tick(1);
    sda_oe <= ~b;
    tick(5);
    scl <= 1'b1;
    tick(3);
    r = sda_in;
    tick(2);
    scl <= 1'b0;
  endtask
  // release data while clock low, raise clock, then pull data low
  task automatic start();
    tick(1);
    sda_oe <= 1'b0;
    tick(5);
    scl <= 1'b1;
    tick(5);
    sda_oe <= 1'b1;
    tick(5);
    scl <= 1'b0;
  endtask
  task automatic stop();
    tick(1);
    sda_oe <= 1'b1;
    tick(5);
    scl <= 1'b1;
    tick(5);
    sda_oe <= 1'b0;
    tick(9);
  endtask
  // one byte out, msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] t, input logic l,
                      output logic [7:0] r, output logic k);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      slot(t[i], b);
      r[i] = b;
    end
    slot(l, b);
    k = ~b;
  endtask
  task automatic wr(input logic [7:0] a, d, output logic ok);
    logic [7:0] x;
    logic k1, k2, k3;
    if (a == ldr_pkg::CFG_OFS) d[5:3] = 3'b011;
    start();
    xfer({ADDR, 1'b0}, 1'b1, x, k1);
    xfer(a, 1'b1, x, k2);
    xfer(d, 1'b1, x, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] x;
    logic k;
    start();
    xfer({ADDR, 1'b0}, 1'b1, x, k);
    xfer(a, 1'b1, x, k);
    start();
    xfer({ADDR, 1'b1}, 1'b1, x, k);
    xfer(8'hff, 1'b1, d, k);
    stop();
  endtask
endmodule

// >>> bench/testbench.sv
// self-checking bench for the register slice
`timescale 1ns/10ps
module testbench;
  logic        mclk, sys_rst, scl, h_oe, oe, sdo, ben, ip, ep, rt, dr, dd;
  logic [7:0]  fl, pwm, dc;
  logic [1:0]  th;
  logic [15:0] cb;
  int          error_cnt, n_checks;
  wire         sda = ~(h_oe | oe); // pulled up, either side pulls low
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  ldr_regs u_dut (.mclk(mclk), .sys_rst(sys_rst),
    .scl_in(scl), .sda_in(sda), .sda_out(sdo), .sda_oe(oe),
    .two_channel_shutdown_flag(fl[5]), .single_channel_shutdown_flag(fl[4]),
    .backlight_on_indicator(fl[3]), .input_overcurrent_flag(fl[2]),
    .thermal_trip_flag(fl[1]), .backlight_enable_control(ben),
    .pwm_duty_level(pwm), .internal_dimming_pwm(ip),
    .external_dimming_input(ep), .dc_current_level_field(dc),
    .switching_rate_select(rt), .short_threshold_select(th),
    .direct_dimming_passthrough(dr), .dimming_drive(dd),
    .combined_brightness(cb));
  ldr_host u_host (.mclk(mclk), .sda_in(sda), .scl(scl), .sda_oe(h_oe));
  task automatic chk(input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic ok;
    u_host.wr(a, d, ok);
    chk({15'h0, ok}, 16'h1);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk({8'h0, d}, {8'h0, exp});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #5_000_000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    {sys_rst, ben, ip, ep, fl, pwm} = {4'h8, 8'h00, 8'h33};
    error_cnt = 0;
    n_checks = 0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(8'h03, 8'ha8);
    wr(8'h03, 8'h00);
    rd(8'h03, 8'ha8);
    rd(8'h05, 8'h00);
    rd(8'h07, 8'hff);
    rd(8'h08, 8'h1f);
    chk({12'h0, dr, rt, th}, 16'h7);
    wr(8'h07, 8'h5a);
    rd(8'h07, 8'h5a);
    pwm <= 8'hff;
    repeat (2) @(negedge mclk);
    chk(cb, 16'h5a * 16'hff);
    chk({8'h0, dc}, 16'h5a);
    $display("reset, id and dc tests done");
    for (int i = 0; i < 8; i++) begin
      wr(8'h08, {5'h0b, 3'(i)});
      rd(8'h08, {5'h0b, 3'(i)});
      chk({12'h0, dr, rt, th}, 16'(i));
    end
    wr(8'h08, 8'h9f);
    repeat (4) begin
      ep <= ~ep;
      repeat (3) @(negedge mclk);
      chk({15'h0, dd}, {15'h0, ep});
      @(posedge mclk);
    end
    wr(8'h08, 8'h1f);
    ip <= 1'b1;
    @(negedge mclk);
    chk({15'h0, dd}, 16'h1);
    $display("configuration test done");
    for (int k = 1; k < 6; k++) begin
      fl <= 8'(1 << k);
      wr(8'h02, 8'h00);
      rd(8'h02, 8'(1 << k) | 8'(k != 3));
    end
    fl <= 8'h00;
    rd(8'h02, 8'h01);
    ben <= 1'b1;
    rd(8'h02, 8'h00);
    wr(8'h02, 8'hfe);
    rd(8'h02, 8'h00);
    $display("status test done");
    print_verdict();
  end
endmodule
